// ===== hw/isec_pkg.sv
// Operation
// - Enable state is modulated onto a carrier and demodulated to drive the gate.
// - Two-wire: enable high starts power transfer; gate rises once secondary is powered.
// - Two-wire: enable low drops the gate and stops power transfer.
// - Three-wire: power transfer runs in periodic bursts regardless of enable.
// - Three-wire: with secondary powered, gate follows enable high and low.
// - Standard enable: gate tracks enable level while secondary power is sufficient.
// - One-shot: each enable rising edge gives one gate pulse, then self-lowers.
// - One-shot only in three-wire mode; two-wire always uses standard enable.
// - Retrigger needs enable low then high again; held high never retriggers.
// - Three-wire power transfer uses fixed 25 us periods with level-set duty.
// - Burst period fixed; on-time from seven levels, higher level longer.
// - Duty levels are (2*level+2)/15 of the period.
// - Out-of-range level selection falls back to the lowest duty level.
// - Level selection is sampled once at power-up and held.
// - One-shot start-up power transfer equals standard enable behaviour.
// - On secondary power loss the gate output is held low.
// - One-shot gate pulse lasts 2.5 us.
// - Primary supply loss with gate high forces gate low after 100 us.
// - Two-wire or three-wire mode is chosen at power-up and held.
package isec_pkg;
    localparam int unsigned CLK_MHZ        = 250;
    localparam int unsigned CARRIER_HZ     = 89_000_000;
    localparam int unsigned CARRIER_DIV    = (CLK_MHZ * 1_000_000) / (2 * CARRIER_HZ);
    localparam int unsigned PERIOD_NS      = 25_000;
    localparam int unsigned PERIOD_CYC     = PERIOD_NS * CLK_MHZ / 1000;
    localparam int unsigned SLOT_CNT       = 15;
    localparam int unsigned SLOT_CYC       = PERIOD_CYC / SLOT_CNT;
    localparam int unsigned ONESHOT_NS     = 2_500;
    localparam int unsigned ONESHOT_CYC    = ONESHOT_NS * CLK_MHZ / 1000;
    localparam int unsigned PLOSS_NS       = 100_000;
    localparam int unsigned PLOSS_CYC      = PLOSS_NS * CLK_MHZ / 1000;
    localparam logic [2:0]  LEVEL_LOW      = 3'h0;
    localparam logic [2:0]  LEVEL_MAX      = 3'h6;
    localparam logic [3:0]  RST_DUTY_SLOTS = 4'h2;
    localparam logic [1:0]  STRAP_SETTLE   = 2'h2;

    typedef enum logic {ISEC_TWO_WIRE, ISEC_THREE_WIRE} isec_mode_t;

    typedef struct packed {
        logic       three_wire;
        logic       one_shot;
        logic [2:0] level;
    } isec_strap_t;

    typedef struct packed {
        logic       gate_drive;
        logic       power_xfer;
        logic       carrier;
    } isec_out_t;
endpackage

// ===== hw/isec_top.sv
`timescale 1ns/1ns
`default_nettype none
module isec_top
    import isec_pkg::*;
#(
    parameter int unsigned PERIOD_CYCLES  = PERIOD_CYC,
    parameter int unsigned PLOSS_CYCLES   = PLOSS_CYC
) (
    // Clock and power-up reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // Pins, asynchronous
    input  wire logic        switch_enable_i,
    input  wire isec_strap_t strap_i,
    input  wire logic        primary_supply_ok_i,
    input  wire logic        secondary_power_ok_i,
    // Outputs
    output var isec_out_t    drv_o,
    output logic             mode_three_wire_o,
    output logic [2:0]       power_level_o
);
    // Two-flop synchronisers for all pin inputs
    logic [2:0]  sync1_ff;
    logic [2:0]  sync2_ff;
    logic        en_s;
    logic        psup_s;
    logic        spwr_s;
    // Straps cross in like any pin
    isec_strap_t strap1_ff;
    isec_strap_t strap2_ff;
    logic [1:0]  strap_cnt_ff;
    logic        strap_seen_ff;
    logic        en_prev_ff;
    isec_mode_t  mode_ff;
    logic        one_shot_ff;
    logic [2:0]  level_ff;
    logic [$clog2(PERIOD_CYCLES+1)-1:0] per_cnt_ff;
    logic [3:0]  on_slots;
    logic        burst_on;
    logic [7:0]  car_cnt_ff;
    logic        car_ff;
    logic        tx_bit_ff;
    logic        rx_bit_ff;
    logic [$clog2(ONESHOT_CYC+1)-1:0] os_cnt_ff;
    logic [$clog2(PLOSS_CYCLES+1)-1:0] pl_cnt_ff;
    logic        pl_timeout_ff;
    logic        nxt_gate;
    logic        xfer_ff;
    logic [$clog2(PERIOD_CYCLES+1)-1:0] xfer_run_ff;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
        end else begin
            sync1_ff <= {switch_enable_i, primary_supply_ok_i, secondary_power_ok_i};
            sync2_ff <= sync1_ff;
        end
    end
    assign en_s   = sync2_ff[2];
    assign psup_s = sync2_ff[1];
    assign spwr_s = sync2_ff[0];

    // Capture waits until the second flop holds a sampled strap
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            strap1_ff    <= '0;
            strap2_ff    <= '0;
            strap_cnt_ff <= 2'h0;
        end else begin
            strap1_ff <= strap_i;
            strap2_ff <= strap1_ff;
            if (strap_cnt_ff != STRAP_SETTLE) begin
                strap_cnt_ff <= strap_cnt_ff + 2'h1;
            end
        end
    end

    function automatic logic [2:0] level_decode(input logic [2:0] code);
        level_decode = (code > LEVEL_MAX) ? LEVEL_LOW : code;
    endfunction

    // Straps are quasi-static, sampled once after reset release
    // Latch at power-up
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            strap_seen_ff <= 1'b0;
            mode_ff       <= ISEC_TWO_WIRE;
            one_shot_ff   <= 1'b0;
            level_ff      <= LEVEL_LOW;
        end else if (!strap_seen_ff && strap_cnt_ff == STRAP_SETTLE) begin
            strap_seen_ff <= 1'b1;
            mode_ff       <= strap2_ff.three_wire ? ISEC_THREE_WIRE : ISEC_TWO_WIRE;
            one_shot_ff   <= strap2_ff.one_shot & strap2_ff.three_wire;
            level_ff      <= level_decode(strap2_ff.level);
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            per_cnt_ff <= '0;
        end else if (per_cnt_ff == $bits(per_cnt_ff)'(PERIOD_CYCLES - 1)) begin
            per_cnt_ff <= '0;
        end else begin
            per_cnt_ff <= per_cnt_ff + 1'b1;
        end
    end

    assign on_slots = 4'({level_ff, 1'b0}) + RST_DUTY_SLOTS;
    assign burst_on = 32'(per_cnt_ff) < 32'(on_slots) * (PERIOD_CYCLES / SLOT_CNT);

    // Power transfer: two-wire gated by enable, three-wire free
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            xfer_ff <= 1'b0;
        end else if (!strap_seen_ff || !psup_s) begin
            xfer_ff <= 1'b0;
        end else if (mode_ff == ISEC_THREE_WIRE) begin
            xfer_ff <= burst_on;
        end else begin
            xfer_ff <= en_s;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            car_cnt_ff <= 8'h00;
            car_ff     <= 1'b0;
        end else if (car_cnt_ff == 8'(CARRIER_DIV - 1)) begin
            car_cnt_ff <= 8'h00;
            car_ff     <= ~car_ff;
        end else begin
            car_cnt_ff <= car_cnt_ff + 8'h01;
        end
    end

    // Transmit bit follows enable every cycle; receiver samples it when car_cnt_ff is zero, else holds last data
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_bit_ff <= 1'b0;
            rx_bit_ff <= 1'b0;
        end else begin
            tx_bit_ff <= en_s;
            if (car_cnt_ff == 8'h00) begin
                rx_bit_ff <= tx_bit_ff;
            end
        end
    end

    // Edge only after a low received bit
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            en_prev_ff <= 1'b0;
        end else begin
            en_prev_ff <= rx_bit_ff;
        end
    end

    // One-shot pulse, rearmed only by a low level
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            os_cnt_ff <= '0;
        end else if (rx_bit_ff && !en_prev_ff) begin
            os_cnt_ff <= $bits(os_cnt_ff)'(ONESHOT_CYC);
        end else if (os_cnt_ff != '0) begin
            os_cnt_ff <= os_cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pl_cnt_ff     <= '0;
            pl_timeout_ff <= 1'b0;
        end else if (psup_s) begin
            pl_cnt_ff     <= '0;
            pl_timeout_ff <= 1'b0;
        end else if (pl_cnt_ff == $bits(pl_cnt_ff)'(PLOSS_CYCLES - 1)) begin
            pl_timeout_ff <= 1'b1;
        end else begin
            pl_cnt_ff <= pl_cnt_ff + 1'b1;
        end
    end

    always_comb begin
        nxt_gate = one_shot_ff ? (os_cnt_ff != '0) : rx_bit_ff;
        // Two-wire low enable kills gate at once
        if (mode_ff == ISEC_TWO_WIRE && !en_s) begin
            nxt_gate = 1'b0;
        end
        if (!spwr_s || pl_timeout_ff || !strap_seen_ff) begin
            nxt_gate = 1'b0;
        end
    end

    // Run length of transfer, saturating; only the checks read it
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            xfer_run_ff <= '0;
        end else if (!xfer_ff) begin
            xfer_run_ff <= '0;
        end else if (xfer_run_ff != '1) begin
            xfer_run_ff <= xfer_run_ff + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            drv_o             <= '0;
            mode_three_wire_o <= 1'b0;
            power_level_o     <= LEVEL_LOW;
        end else begin
            drv_o             <= '{gate_drive: nxt_gate, power_xfer: xfer_ff,
                                   carrier: car_ff & xfer_ff};
            mode_three_wire_o <= (mode_ff == ISEC_THREE_WIRE);
            power_level_o     <= level_ff;
        end
    end

    // Assertions
    AST_KEEP_OFF: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !spwr_s |=> !drv_o.gate_drive) else $error("gate high without secondary power");
    AST_TWO_WIRE_LOW: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (mode_ff == ISEC_TWO_WIRE && !en_s && strap_seen_ff) |=> !drv_o.gate_drive)
        else $error("two-wire low enable left gate high");
    AST_TWO_WIRE_XFER: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (mode_ff == ISEC_TWO_WIRE && strap_seen_ff && psup_s) |=> xfer_ff == $past(en_s))
        else $error("two-wire transfer does not follow enable");
    AST_NO_OS_2W: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (mode_ff == ISEC_TWO_WIRE) |-> !one_shot_ff) else $error("one-shot in two-wire");
    AST_LEVEL_RANGE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        level_ff <= LEVEL_MAX) else $error("power level out of range");
    AST_STRAP_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(strap_seen_ff) |-> $stable(level_ff) && $stable(mode_ff))
        else $error("strap changed after power-up");
    AST_OS_LEN: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (one_shot_ff && rx_bit_ff && !en_prev_ff) |=> os_cnt_ff == ONESHOT_CYC)
        else $error("one-shot length wrong");
    AST_OS_NO_RETRIG: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (os_cnt_ff == '0 && en_prev_ff && rx_bit_ff) |=> os_cnt_ff == '0)
        else $error("held-high retriggered");
    AST_BURST_OFF: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (mode_ff == ISEC_THREE_WIRE && !burst_on) |=> !xfer_ff)
        else $error("burst past on-time");
    AST_PLOSS: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        pl_timeout_ff |=> !drv_o.gate_drive) else $error("timeout left gate high");
    COV_OS: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        one_shot_ff && drv_o.gate_drive);
    COV_3W: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        mode_three_wire_o && drv_o.power_xfer);
    COV_PL: cover property (@(posedge ref_clk_i) disable iff (rst_i) pl_timeout_ff);
    COV_2W: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        !mode_three_wire_o && drv_o.gate_drive);
    COV_OS_EDGE: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        one_shot_ff && rx_bit_ff && !en_prev_ff);

    AST_STD_FOLLOW: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (strap_seen_ff && !one_shot_ff && spwr_s && !pl_timeout_ff &&
         (mode_ff == ISEC_THREE_WIRE || en_s)) |=> drv_o.gate_drive == $past(rx_bit_ff))
        else $error("standard enable does not follow the received bit");

    AST_THREE_WIRE_XFER: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (mode_ff == ISEC_THREE_WIRE && strap_seen_ff && psup_s) |=> xfer_ff == $past(burst_on))
        else $error("three-wire transfer does not follow the burst");

    AST_TWO_WIRE_STOP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (mode_ff == ISEC_TWO_WIRE && strap_seen_ff && !en_s) |=> !xfer_ff)
        else $error("two-wire transfer with enable low");

    AST_PRIM_OFF: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !psup_s |=> !xfer_ff)
        else $error("transfer without primary supply");

    AST_OS_END: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (one_shot_ff && os_cnt_ff == '0) |=> !drv_o.gate_drive)
        else $error("one-shot gate high after pulse");

    AST_OS_COUNT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (os_cnt_ff != '0 && !(rx_bit_ff && !en_prev_ff)) |=>
            os_cnt_ff == $past(os_cnt_ff) - 1'b1)
        else $error("one-shot counter skipped");

    AST_RX_SAMPLE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (car_cnt_ff == 8'h00) |=> rx_bit_ff == $past(tx_bit_ff))
        else $error("receiver missed the carrier slot");

    AST_CARRIER_IDLE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !drv_o.power_xfer |-> !drv_o.carrier)
        else $error("carrier without power transfer");

    AST_XFER_RUN: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (mode_ff == ISEC_THREE_WIRE) |->
            32'(xfer_run_ff) <= 32'(on_slots) * (PERIOD_CYCLES / SLOT_CNT))
        else $error("burst longer than level on-time");

    AST_MODE_OUT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(strap_seen_ff) |-> mode_three_wire_o == (mode_ff == ISEC_THREE_WIRE))
        else $error("mode output differs from latched mode");

    AST_TIMEOUT_SET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (!psup_s && pl_cnt_ff == $bits(pl_cnt_ff)'(PLOSS_CYCLES - 1)) |=> pl_timeout_ff)
        else $error("primary-loss timeout not raised");

    AST_PLOSS_CLEAR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        psup_s |=> !pl_timeout_ff)
        else $error("timeout with primary supply present");
endmodule
`default_nettype wire

// ===== bench/isec_host.sv
`timescale 1ns/1ns
`default_nettype none
module isec_host #(
    parameter int unsigned LOW_MIN = 4
) (
    // Clock and request from the bench
    input  wire logic ref_clk_i,
    input  wire logic en_req_i,
    // Enable pin
    output var logic  switch_enable_o
);
    int unsigned low_cnt = 0;

    initial switch_enable_o = 1'b0;

    always @(posedge ref_clk_i) begin
        if (!en_req_i) begin
            switch_enable_o <= 1'b0;
            if (low_cnt < LOW_MIN) begin
                low_cnt <= low_cnt + 1;
            end
        end else begin
            // Too short a low would be lost in the pin synchroniser
            if (low_cnt == LOW_MIN) begin
                switch_enable_o <= 1'b1;
            end
            if (switch_enable_o) begin
                low_cnt <= 0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    import isec_pkg::*;
    localparam int unsigned PER = 150;
    localparam int unsigned PL  = 50;
    logic        clk         = 1'b0;
    logic        rst         = 1'b1;
    logic        en_req      = 1'b0;
    logic        prim_ok     = 1'b1;
    logic        sec_ok      = 1'b1;
    isec_strap_t strap       = '0;
    logic        sw_en;
    isec_out_t   drv;
    logic        mode3;
    logic [2:0]  lvl;
    int          failures    = 0;
    int          comparisons = 0;
    int          n;
    int          t;
    int          s;

    isec_top #(.PERIOD_CYCLES(PER), .PLOSS_CYCLES(PL)) i_dut (
        .ref_clk_i(clk), .rst_i(rst), .switch_enable_i(sw_en), .strap_i(strap),
        .primary_supply_ok_i(prim_ok), .secondary_power_ok_i(sec_ok),
        .drv_o(drv), .mode_three_wire_o(mode3), .power_level_o(lvl));
    isec_host i_host (.ref_clk_i(clk), .en_req_i(en_req), .switch_enable_o(sw_en));

    initial forever #2 clk = ~clk;

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic test_done;
        if (failures == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic por(input logic tw, input logic os, input logic [2:0] lv);
        rst = 1'b1;
        en_req = 1'b0;
        strap = '{three_wire: tw, one_shot: os, level: lv};
        cyc(4);
        rst = 1'b0;
        cyc(2);
        // Straps wander after the second flop holds them; the latch must ignore them
        strap = 5'($urandom);
        cyc(4);
    endtask

    task automatic gate_wait(input logic v, input int max);
        n = 0;
        while (drv.gate_drive !== v && n < max) begin
            cyc(1);
            n++;
        end
        chk("gate_drive", v, drv.gate_drive);
    endtask

    function automatic int exp_on(input int c);
        int l;
        l = (c == 7) ? 0 : c;
        return (2 * l + 2) * PER / 15;
    endfunction

    initial begin
        void'($urandom(90819));
        for (int c = 0; c < 8; c++) begin
            por(1'b1, 1'b0, 3'(c));
            chk("mode", 1, mode3);
            chk("level", (c == 7) ? 0 : c, lvl);
            n = 0;
            t = 0;
            s = 0;
            repeat (PER) begin
                cyc(1);
                n += drv.power_xfer;
                t += drv.carrier;
                s += drv.carrier & ~drv.power_xfer;
            end
            chk("duty", exp_on(c), n);
            chk("carrier", 1, t >= exp_on(c) / 2 - 1 && t <= exp_on(c) / 2 + 1);
            chk("carrier idle", 0, s);
        end
        en_req = 1'b1;
        gate_wait(1'b1, 12);
        cyc(20 + $urandom % 50);
        chk("gate held", 1, drv.gate_drive);
        en_req = 1'b0;
        gate_wait(1'b0, 8);
        en_req = 1'b1;
        gate_wait(1'b1, 12);
        sec_ok = 1'b0;
        gate_wait(1'b0, 6);
        cyc(20);
        chk("gate kept off", 0, drv.gate_drive);
        sec_ok = 1'b1;
        gate_wait(1'b1, 12);
        prim_ok = 1'b0;
        cyc(PL - 10);
        chk("gate before timeout", 1, drv.gate_drive);
        gate_wait(1'b0, 20);
        prim_ok = 1'b1;
        por(1'b0, 1'b1, 3'h1);
        chk("mode", 0, mode3);
        chk("xfer off", 0, drv.power_xfer);
        en_req = 1'b1;
        gate_wait(1'b1, 12);
        chk("xfer on", 1, drv.power_xfer);
        cyc(1000);
        chk("no one-shot", 1, drv.gate_drive);
        en_req = 1'b0;
        gate_wait(1'b0, 8);
        cyc(4);
        chk("xfer stop", 0, drv.power_xfer);
        por(1'b1, 1'b1, 3'h6);
        repeat (2) begin
            en_req = 1'b1;
            gate_wait(1'b1, 12);
            n = 0;
            while (drv.gate_drive === 1'b1 && n < 700) begin
                cyc(1);
                n++;
            end
            chk("pulse len", 1, n >= ONESHOT_CYC - 2 && n <= ONESHOT_CYC + 2);
            cyc(500);
            chk("no retrigger", 0, drv.gate_drive);
            en_req = 1'b0;
            cyc(10);
        end
        test_done();
    end

    initial begin
        cyc(20000);
        failures++;
        test_done();
    end
endmodule
`default_nettype wire
